// >>> verilog/pulse_gen_regs.vh
`ifndef PULSE_GEN_REGS_VH
`define PULSE_GEN_REGS_VH

// Core clock period and microsecond tick period
`define CLK_PERIOD_NS 4
`define TICK_PERIOD_NS 1000
// Prescaler length, derived from the two times above
`define US_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

// Generator count and counter width
`define NUM_GEN 6
`define CNT_W 32

// Least accepted microsecond delay and width
`define MIN_US 32'h0000000a

// Trigger source select codes
`define SRC_W 3
`define SRC_IMMEDIATE 3'h0
`define SRC_TTL_IN0 3'h1
`define SRC_TTL_IN1 3'h2
`define SRC_ISO_TRIG_ZERO 3'h3
`define SRC_ISO_IN5 3'h4
`define SRC_ISO_IN8 3'h5
`define NUM_TRIG 5

// Isolated input positions
`define ISO_W 12
`define ISO_LATCH_BIT 5
`define ISO_ENC_A_BIT 6
`define ISO_ENC_B_BIT 7
`define ISO_TRIG8_BIT 8
`define PSEL_W 6

// Isolated output count
`define ISO_OUT_W 4

// Channel states
`define ST_IDLE 2'h0
`define ST_DELAY 2'h1
`define ST_WIDTH 2'h2

`endif

// >>> verilog/pulse_timer_channel.v
`timescale 1ns/100ps
`default_nettype none
`include "pulse_gen_regs.vh"

module pulse_timer_channel #(
    parameter CNT_W = `CNT_W
) (
    input wire clk,
    input wire rstn,
    input wire run,
    input wire immediate,
    input wire trig_hit,
    input wire us_tick,
    input wire enc_step,
    input wire delay_in_counts,
    input wire low_true,
    input wire [CNT_W-1:0] delay_val,
    input wire [CNT_W-1:0] width_val,
    output reg pulse_out,
    output reg busy
);

    reg [1:0] state_ff; // Sequencer state
    reg [1:0] nxt_state;
    reg [CNT_W-1:0] cnt_ff; // Shared delay and width counter
    reg [CNT_W-1:0] nxt_cnt;
    reg nxt_pulse;
    wire [CNT_W-1:0] delay_eff; // Delay after range floor
    wire [CNT_W-1:0] width_eff; // Width after range floor
    wire delay_step; // Delay unit advance

    // Microsecond delay floored at ten, encoder delay taken whole
    assign delay_eff = delay_in_counts ? delay_val :
                       ((delay_val < `MIN_US) ? `MIN_US : delay_val);
    // Width floored at ten microseconds
    assign width_eff = (width_val < `MIN_US) ? `MIN_US : width_val;
    // Delay advances on encoder transitions or microsecond ticks
    assign delay_step = delay_in_counts ? enc_step : us_tick;

    // Sequencer next state
    always @* begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_pulse = pulse_out;
        if (!run) begin
            // Stopped: idle, deasserted
            nxt_state = `ST_IDLE;
            nxt_cnt = {CNT_W{1'b0}};
            nxt_pulse = low_true;
        end else begin
            case (state_ff)
                `ST_IDLE: begin
                    nxt_pulse = low_true;
                    // Software start or qualifying edge starts delay
                    if (immediate || trig_hit) begin
                        nxt_state = `ST_DELAY;
                        nxt_cnt = {CNT_W{1'b0}};
                    end
                end
                `ST_DELAY: begin
                    if (cnt_ff == delay_eff) begin
                        // Delay over: assertion edge
                        nxt_state = `ST_WIDTH;
                        nxt_cnt = {CNT_W{1'b0}};
                        nxt_pulse = ~low_true;
                    end else if (delay_step) begin
                        nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
                `ST_WIDTH: begin
                    if (cnt_ff == width_eff) begin
                        // Width over: deassertion edge
                        nxt_pulse = low_true;
                        nxt_cnt = {CNT_W{1'b0}};
                        // Immediate mode repeats, triggered mode rearms
                        nxt_state = immediate ? `ST_DELAY : `ST_IDLE;
                    end else if (us_tick) begin
                        nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
                default: begin
                    nxt_state = `ST_IDLE;
                    nxt_cnt = {CNT_W{1'b0}};
                    nxt_pulse = low_true;
                end
            endcase
        end
    end

    // Sequencer registers
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= `ST_IDLE;
            cnt_ff <= {CNT_W{1'b0}};
            pulse_out <= 1'b0;
            busy <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            pulse_out <= nxt_pulse;
            busy <= (nxt_state != `ST_IDLE);
        end
    end

endmodule
`default_nettype wire

// >>> verilog/pulse_gen_bank.v
`timescale 1ns/100ps
`default_nettype none
`include "pulse_gen_regs.vh"

module pulse_gen_bank #(
    parameter NUM_GEN = `NUM_GEN,
    parameter CNT_W = `CNT_W,
    parameter US_CYCLES = `US_CYCLES
) (
    input wire CLK,
    input wire RSTN,
    // Fast logic-level inputs
    input wire [1:0] TTL_IN,
    // Isolated trigger line zero
    input wire ISOLATED_TRIGGER_LINE_ZERO,
    // Isolated inputs 0 to 11
    input wire [`ISO_W-1:0] ISO_IN,
    // Per-generator run mode, high is Start
    input wire [NUM_GEN-1:0] RUN,
    // Per-generator source select, three bits each
    input wire [NUM_GEN*`SRC_W-1:0] SRC_SEL,
    // Per-generator trigger edge, high is falling
    input wire [NUM_GEN-1:0] TRIG_FALLING,
    // Per-generator output polarity, high is low-true
    input wire [NUM_GEN-1:0] OUT_LOW_TRUE,
    // Per-generator delay unit, high is encoder counts
    input wire [NUM_GEN-1:0] DELAY_IN_COUNTS,
    // Per-generator delay and width
    input wire [NUM_GEN*CNT_W-1:0] DELAY_VAL,
    input wire [NUM_GEN*CNT_W-1:0] WIDTH_VAL,
    // Product selection latch enable
    input wire PSEL_LATCH_EN,
    // Isolated output commands and overcurrent trips
    input wire [`ISO_OUT_W-1:0] ISO_OUT_CMD,
    input wire [`ISO_OUT_W-1:0] ISO_OC_TRIP,
    // Timed pulse outputs and activity
    output wire [NUM_GEN-1:0] PULSE_OUT,
    output wire [NUM_GEN-1:0] PULSE_BUSY,
    // General input readback
    output reg [1:0] TTL_GP_IN,
    output reg TRIG_ZERO_GP_IN,
    output reg [`ISO_W-1:0] ISO_GP_IN,
    // Product selection data
    output reg [`PSEL_W-1:0] PSEL_DATA,
    // Isolated output drive and disable status
    output reg [`ISO_OUT_W-1:0] ISO_OUT,
    output reg [`ISO_OUT_W-1:0] ISO_OUT_DISABLED
);

    localparam IN_W = `ISO_W + 3; // All synchronised inputs
    localparam [15:0] US_LAST = US_CYCLES - 1; // Prescaler wrap value

    reg [IN_W-1:0] in_s1_ff; // First synchroniser stage
    reg [IN_W-1:0] in_s2_ff; // Second synchroniser stage
    reg [IN_W-1:0] in_d_ff; // Previous synchronised value
    wire [IN_W-1:0] in_raw; // Gathered raw inputs
    wire [`ISO_W-1:0] iso_s; // Synchronised isolated inputs
    wire [`ISO_W-1:0] iso_d; // Delayed isolated inputs
    wire [`NUM_TRIG-1:0] trig_lvl; // Trigger levels
    wire [`NUM_TRIG-1:0] trig_prev; // Trigger levels one cycle older
    reg [15:0] pre_cnt_ff; // Microsecond prescaler
    reg us_tick_ff; // Microsecond tick pulse
    reg enc_step_ff; // Encoder transition pulse
    wire enc_change; // Either phase changed
    wire psel_strobe; // Rising edge on latch line
    reg [`ISO_OUT_W-1:0] cmd_d_ff; // Previous isolated commands
    reg [`ISO_OUT_W-1:0] nxt_disabled;

    // Raw input order: isolated inputs, trigger zero, fast inputs
    assign in_raw = {TTL_IN, ISOLATED_TRIGGER_LINE_ZERO, ISO_IN};
    assign iso_s = in_s2_ff[`ISO_W-1:0];
    assign iso_d = in_d_ff[`ISO_W-1:0];

    // Two-stage synchroniser plus edge history
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            in_s1_ff <= {IN_W{1'b0}};
            in_s2_ff <= {IN_W{1'b0}};
            in_d_ff <= {IN_W{1'b0}};
        end else begin
            in_s1_ff <= in_raw;
            in_s2_ff <= in_s1_ff;
            in_d_ff <= in_s2_ff;
        end
    end

    // Trigger lines from fast and isolated inputs
    assign trig_lvl = {iso_s[`ISO_TRIG8_BIT], iso_s[`ISO_LATCH_BIT],
                       in_s2_ff[`ISO_W], in_s2_ff[`ISO_W+2:`ISO_W+1]};
    assign trig_prev = {iso_d[`ISO_TRIG8_BIT], iso_d[`ISO_LATCH_BIT],
                        in_d_ff[`ISO_W], in_d_ff[`ISO_W+2:`ISO_W+1]};

    // Microsecond prescaler
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pre_cnt_ff <= 16'h0000;
            us_tick_ff <= 1'b0;
        end else if (pre_cnt_ff == US_LAST) begin
            // Wrap and emit one tick
            pre_cnt_ff <= 16'h0000;
            us_tick_ff <= 1'b1;
        end else begin
            pre_cnt_ff <= pre_cnt_ff + 16'h0001;
            us_tick_ff <= 1'b0;
        end
    end

    // Every phase transition is one encoder count
    assign enc_change = (iso_s[`ISO_ENC_A_BIT] ^ iso_d[`ISO_ENC_A_BIT]) |
                        (iso_s[`ISO_ENC_B_BIT] ^ iso_d[`ISO_ENC_B_BIT]);

    // Encoder step pulse
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            enc_step_ff <= 1'b0;
        end else begin
            enc_step_ff <= enc_change;
        end
    end

    // Generator bank
    genvar g;
    generate
        for (g = 0; g < NUM_GEN; g = g + 1) begin : gen_ch
            wire [`SRC_W-1:0] src; // Chosen source
            wire sel_lvl; // Chosen trigger level
            wire sel_prev; // Chosen trigger level one cycle older
            wire hit; // Qualifying edge
            wire imm; // Immediate source
            wire valid_src; // Source names a real trigger
            wire [2:0] idx; // Trigger index

            assign src = SRC_SEL[g*`SRC_W +: `SRC_W];
            assign imm = (src == `SRC_IMMEDIATE);
            assign valid_src = (src >= `SRC_TTL_IN0) && (src <= `SRC_ISO_IN8);
            assign idx = src - 3'h1;
            // Unused codes never trigger
            assign sel_lvl = valid_src ? trig_lvl[idx] : 1'b0;
            assign sel_prev = valid_src ? trig_prev[idx] : 1'b0;
            // Own edge choice per generator
            assign hit = valid_src && (TRIG_FALLING[g] ? (sel_prev & ~sel_lvl)
                                                      : (sel_lvl & ~sel_prev));

            // One timer per output
            pulse_timer_channel #(
                .CNT_W(CNT_W)
            ) u_ch (
                .clk(CLK),
                .rstn(RSTN),
                .run(RUN[g]),
                .immediate(imm),
                .trig_hit(hit),
                .us_tick(us_tick_ff),
                .enc_step(enc_step_ff),
                .delay_in_counts(DELAY_IN_COUNTS[g]),
                .low_true(OUT_LOW_TRUE[g]),
                .delay_val(DELAY_VAL[g*CNT_W +: CNT_W]),
                .width_val(WIDTH_VAL[g*CNT_W +: CNT_W]),
                .pulse_out(PULSE_OUT[g]),
                .busy(PULSE_BUSY[g])
            );
        end
    endgenerate

    // General input readback from synchronised values
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            TTL_GP_IN <= 2'h0;
            TRIG_ZERO_GP_IN <= 1'b0;
            ISO_GP_IN <= 12'h000;
        end else begin
            TTL_GP_IN <= in_s2_ff[`ISO_W+2:`ISO_W+1];
            TRIG_ZERO_GP_IN <= in_s2_ff[`ISO_W];
            ISO_GP_IN <= iso_s;
        end
    end

    // Rising edge on isolated line five
    assign psel_strobe = iso_s[`ISO_LATCH_BIT] & ~iso_d[`ISO_LATCH_BIT];

    // Product selection: live while latch disabled, else latched on strobe
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            PSEL_DATA <= 6'h00;
        end else if (!PSEL_LATCH_EN) begin
            PSEL_DATA <= iso_s[`PSEL_W-1:0];
        end else if (psel_strobe) begin
            PSEL_DATA <= iso_s[`PSEL_W-1:0];
        end
    end

    // Trip disables; a command toggle re-enables; trip wins
    always @* begin
        nxt_disabled = ISO_OC_TRIP | (ISO_OUT_DISABLED & ~(ISO_OUT_CMD ^ cmd_d_ff));
    end

    // Isolated output drive with protection
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cmd_d_ff <= 4'h0;
            ISO_OUT_DISABLED <= 4'h0;
            ISO_OUT <= 4'h0;
        end else begin
            cmd_d_ff <= ISO_OUT_CMD;
            ISO_OUT_DISABLED <= nxt_disabled;
            ISO_OUT <= ISO_OUT_CMD & ~nxt_disabled;
        end
    end

endmodule
`default_nettype wire

// >>> dv/pulse_gen_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module pulse_gen_checker #(
    parameter NUM_GEN = 6,
    parameter CNT_W = 32
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic [1:0] TTL_IN,
    input wire logic [NUM_GEN-1:0] RUN,
    input wire logic [NUM_GEN*3-1:0] SRC_SEL,
    input wire logic [NUM_GEN-1:0] TRIG_FALLING,
    input wire logic [NUM_GEN-1:0] OUT_LOW_TRUE,
    input wire logic [NUM_GEN-1:0] DELAY_IN_COUNTS,
    input wire logic [NUM_GEN*CNT_W-1:0] DELAY_VAL,
    input wire logic [3:0] ISO_OC_TRIP,
    input wire logic [NUM_GEN-1:0] PULSE_OUT,
    input wire logic [NUM_GEN-1:0] PULSE_BUSY,
    input wire logic [3:0] ISO_OUT,
    input wire logic [3:0] ISO_OUT_DISABLED
);
    // One clock domain, reset aborts every check
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // Stopped generators drop activity and sit deasserted
    a_stop_idles: assert property (1'b1 |=> (PULSE_BUSY & ~$past(RUN)) == '0)
        else $error("busy while stopped");
    a_stop_level: assert property (1'b1 |=> ((PULSE_OUT ^ $past(OUT_LOW_TRUE)) & ~$past(RUN)) == '0)
        else $error("asserted while stopped");
    // An asserted output belongs to an active sequence
    a_out_needs_busy: assert property ($past(RSTN) |-> ((PULSE_OUT ^ $past(OUT_LOW_TRUE)) & ~PULSE_BUSY) == '0)
        else $error("asserted without busy");
    // Immediate source starts on the run edge; zero count delay asserts one cycle after busy
    a_imm_start: assert property ($rose(RUN[0]) && SRC_SEL[2:0] == 3'h0 |=> PULSE_BUSY[0])
        else $error("immediate start missed");
    a_zero_count: assert property ($rose(PULSE_BUSY[0]) && DELAY_IN_COUNTS[0] && DELAY_VAL[CNT_W-1:0] == '0
        |=> PULSE_OUT[0] ^ OUT_LOW_TRUE[0])
        else $error("zero count delay late");
    // Microsecond delay and width never collapse below the floor
    a_delay_floor: assert property ($rose(PULSE_BUSY[1]) && !DELAY_IN_COUNTS[1]
        |-> !(PULSE_OUT[1] ^ OUT_LOW_TRUE[1]) [*8])
        else $error("delay too short");
    a_width_floor: assert property ($rose(PULSE_OUT[1] ^ OUT_LOW_TRUE[1])
        |=> ((PULSE_OUT[1] ^ OUT_LOW_TRUE[1]) || !$past(RUN[1])) [*7])
        else $error("width too short");
    // Rising trigger on fast input zero starts generator one
    a_trig_start: assert property (RUN[1] && !PULSE_BUSY[1] && SRC_SEL[5:3] == 3'h1 && !TRIG_FALLING[1]
        && $rose(TTL_IN[0]) |-> ##[1:4] PULSE_BUSY[1])
        else $error("trigger not taken");
    // Overcurrent trip turns the output off
    a_trip_off: assert property (ISO_OC_TRIP != '0 |=> (ISO_OUT & $past(ISO_OC_TRIP)) == '0
        && (ISO_OUT_DISABLED & $past(ISO_OC_TRIP)) == $past(ISO_OC_TRIP))
        else $error("trip not disabling");
    // Main scenarios reached
    c_falling_start: cover property ($rose(PULSE_BUSY[2]));
    c_imm_end: cover property ($fell(PULSE_BUSY[0]));
    c_trip_cleared: cover property (ISO_OUT_DISABLED[0] ##1 !ISO_OUT_DISABLED[0]);
endmodule
bind pulse_gen_bank pulse_gen_checker #(.NUM_GEN(NUM_GEN), .CNT_W(CNT_W)) pulse_gen_checker_i (
    .CLK(CLK), .RSTN(RSTN), .TTL_IN(TTL_IN), .RUN(RUN), .SRC_SEL(SRC_SEL), .TRIG_FALLING(TRIG_FALLING),
    .OUT_LOW_TRUE(OUT_LOW_TRUE), .DELAY_IN_COUNTS(DELAY_IN_COUNTS), .DELAY_VAL(DELAY_VAL),
    .ISO_OC_TRIP(ISO_OC_TRIP), .PULSE_OUT(PULSE_OUT), .PULSE_BUSY(PULSE_BUSY), .ISO_OUT(ISO_OUT),
    .ISO_OUT_DISABLED(ISO_OUT_DISABLED));
`default_nettype wire

// >>> dv/trig_enc_model.sv
`timescale 1ns/100ps
`default_nettype none
module trig_enc_model (
    input wire logic clk,
    output logic [1:0] ttl,
    output logic trig0,
    output logic [11:0] iso
);
    // All lines rest low
    initial begin
        ttl = 2'h0;
        trig0 = 1'b0;
        iso = 12'h000;
    end
    // Drive the trigger line behind source code src
    task automatic set_line(input int src, input logic lvl);
        @(posedge clk);
        case (src)
            1: ttl[0] <= lvl;
            2: ttl[1] <= lvl;
            3: trig0 <= lvl;
            4: iso[5] <= lvl;
            default: iso[8] <= lvl;
        endcase
    endtask
    // Product selection data lines zero to four
    task automatic set_data(input logic [4:0] v);
        @(posedge clk);
        iso[4:0] <= v;
    endtask
    // One quadrature step, phases A and B in Gray order
    task automatic enc_step();
        @(posedge clk);
        if (iso[6] == iso[7]) begin
            iso[6] <= ~iso[6];
        end else begin
            iso[7] <= ~iso[7];
        end
    endtask
endmodule
`default_nettype wire

// >>> dv/test_pulse_gen_bank.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fail_count++; \
    $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module test_pulse_gen_bank;
    localparam int U = 4; // Short microsecond in clocks
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [5:0] run = '0, fall = '0, lowt = '0, cnts = '0;
    logic [17:0] src = '0;
    logic [191:0] dly = '0, wid = '0;
    logic [3:0] cmd = '0, trip = '0;
    logic [1:0] ttl;
    logic trig0;
    logic [11:0] iso;
    wire [5:0] pout, busy;
    wire [1:0] gp_ttl;
    wire gp_trig0;
    wire [11:0] iso_gp;
    wire [5:0] psel;
    logic psel_en = 1'b0;
    wire [3:0] iso_out, iso_dis;
    int fail_count = 0, checked = 0;
    always #2 clk = ~clk;
    trig_enc_model trig_enc_model_i (.clk(clk), .ttl(ttl), .trig0(trig0), .iso(iso));
    pulse_gen_bank #(.US_CYCLES(U)) pulse_gen_bank_i (.CLK(clk), .RSTN(rstn), .TTL_IN(ttl),
        .ISOLATED_TRIGGER_LINE_ZERO(trig0), .ISO_IN(iso), .RUN(run), .SRC_SEL(src), .TRIG_FALLING(fall),
        .OUT_LOW_TRUE(lowt), .DELAY_IN_COUNTS(cnts), .DELAY_VAL(dly), .WIDTH_VAL(wid), .PSEL_LATCH_EN(psel_en),
        .ISO_OUT_CMD(cmd), .ISO_OC_TRIP(trip), .PULSE_OUT(pout), .PULSE_BUSY(busy), .TTL_GP_IN(gp_ttl),
        .TRIG_ZERO_GP_IN(gp_trig0), .ISO_GP_IN(iso_gp), .PSEL_DATA(psel), .ISO_OUT(iso_out),
        .ISO_OUT_DISABLED(iso_dis));
    // Counts and verdict
    task automatic finish_test();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Cycles until generator g shows asserted level lvl
    task automatic wait_act(input int g, input logic lvl, input int lim, output int n);
        n = 0;
        while (((pout[g] ^ lowt[g]) !== lvl) && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask
    // Program a generator while stopped, then start it
    task automatic cfg(input int g, input logic [2:0] s, input logic f, input logic lt, input logic c,
        input logic [31:0] d, input logic [31:0] w);
        @(posedge clk);
        run[g] <= 1'b0;
        src[3*g+:3] <= s;
        fall[g] <= f;
        lowt[g] <= lt;
        cnts[g] <= c;
        dly[32*g+:32] <= d;
        wid[32*g+:32] <= w;
        @(posedge clk);
        run[g] <= 1'b1;
    endtask
    // Immediate source repeats until stopped mid-pulse
    task automatic t_imm();
        int n;
        cfg(0, 3'h0, 1'b0, 1'b0, 1'b1, 32'h0, 32'h3);
        wait_act(0, 1'b1, 10, n);
        `CHK("imm delay", 1'b1, n <= 4)
        wait_act(0, 1'b0, 60, n);
        `CHK("imm width", 1'b1, n inside {[9*U:11*U+2]})
        wait_act(0, 1'b1, 4, n);
        `CHK("imm repeat", 1'b1, n <= 2)
        repeat (5) @(posedge clk);
        run[0] <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("stop busy", 2'h0, {busy[0], pout[0]})
    endtask
    // One pulse per rising trigger, then rearm
    task automatic t_trig();
        int n;
        cfg(1, 3'h1, 1'b0, 1'b0, 1'b0, 32'h1, 32'hc);
        repeat (20) @(posedge clk);
        `CHK("no trig", 1'b0, busy[1])
        for (int k = 0; k < 2; k++) begin
            trig_enc_model_i.set_line(1, 1'b1);
            wait_act(1, 1'b1, 60, n);
            `CHK("trig delay", 1'b1, n inside {[9*U:11*U+4]})
            wait_act(1, 1'b0, 70, n);
            `CHK("trig width", 1'b1, n inside {[11*U:13*U+1]})
            trig_enc_model_i.set_line(1, 1'b0);
            repeat (60) @(posedge clk);
            `CHK("one pulse", 1'b0, busy[1])
        end
    endtask
    // Shared trigger, opposite edges and polarities
    task automatic t_edge();
        int n;
        cfg(2, 3'h5, 1'b1, 1'b1, 1'b0, 32'ha, 32'ha);
        cfg(4, 3'h5, 1'b0, 1'b0, 1'b0, 32'ha, 32'ha);
        `CHK("idle low-true", 1'b1, pout[2])
        trig_enc_model_i.set_line(5, 1'b1);
        repeat (6) @(posedge clk);
        `CHK("rise picks", 2'h2, {busy[4], busy[2]})
        trig_enc_model_i.set_line(5, 1'b0);
        wait_act(2, 1'b1, 60, n);
        `CHK("fall pulse", 1'b0, pout[2])
        repeat (120) @(posedge clk);
        run <= '0;
    endtask
    // Delay counted in encoder transitions
    task automatic t_enc();
        int n;
        cfg(3, 3'h3, 1'b0, 1'b0, 1'b1, 32'h4, 32'ha);
        trig_enc_model_i.set_line(3, 1'b1);
        repeat (40) @(posedge clk);
        `CHK("enc waits", 1'b1, busy[3] & ~pout[3])
        `CHK("gp trig0", 1'b1, gp_trig0)
        for (int k = 0; k < 4; k++) begin
            `CHK("enc early", 1'b0, pout[3])
            trig_enc_model_i.enc_step();
            repeat (8) @(posedge clk);
        end
        `CHK("enc count", 1'b1, pout[3])
        wait_act(3, 1'b0, 60, n);
        `CHK("enc width", 1'b1, n inside {[8*U:11*U]})
        trig_enc_model_i.set_line(3, 1'b0);
    endtask
    // Sixth generator on fast input one, plus readback
    task automatic t_gp();
        cfg(5, 3'h2, 1'b0, 1'b0, 1'b0, 32'ha, 32'ha);
        trig_enc_model_i.set_line(2, 1'b1);
        repeat (6) @(posedge clk);
        `CHK("gen five", 1'b1, busy[5])
        `CHK("gp read", 2'h2, gp_ttl)
    endtask
    // Product selection live, held, then latched on line five
    task automatic t_psel();
        trig_enc_model_i.set_data(5'h15);
        repeat (5) @(posedge clk);
        `CHK("live select", 6'h15, psel)
        `CHK("gp iso", 12'h015, iso_gp)
        psel_en <= 1'b1;
        trig_enc_model_i.set_data(5'h0a);
        repeat (5) @(posedge clk);
        `CHK("held select", 6'h15, psel)
        trig_enc_model_i.set_line(4, 1'b1);
        repeat (5) @(posedge clk);
        `CHK("latched select", 6'h2a, psel)
    endtask
    // Trip holds output off until the command toggles
    task automatic t_iso();
        @(posedge clk);
        cmd <= 4'h1;
        repeat (2) @(posedge clk);
        trip <= 4'h1;
        @(posedge clk);
        trip <= 4'h0;
        repeat (3) @(posedge clk);
        `CHK("trip off", 2'h1, {iso_out[0], iso_dis[0]})
        cmd <= 4'h0;
        @(posedge clk);
        cmd <= 4'h1;
        repeat (3) @(posedge clk);
        `CHK("toggle on", 2'h2, {iso_out[0], iso_dis[0]})
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        t_imm();
        t_trig();
        t_edge();
        t_enc();
        t_gp();
        t_psel();
        t_iso();
        finish_test();
    end
    // Hang guard
    initial begin
        #100000;
        fail_count++;
        finish_test();
    end
endmodule
`default_nettype wire
